// ---- core/cris_defs.vh ----
// Constants for the core reset and initial-state sequencer.
`ifndef CRIS_DEFS_VH
`define CRIS_DEFS_VH

// Register indices on the plain register port.
`define CRIS_ADDR_MACHINE_STATE   4'h0
`define CRIS_ADDR_DEBUG_CTRL_ZERO 4'h1
`define CRIS_ADDR_DEBUG_CTRL_ONE  4'h2
`define CRIS_ADDR_DEBUG_EVENT_LOG 4'h3
`define CRIS_ADDR_DATA_CACHEABLE  4'h4
`define CRIS_ADDR_INSTR_CACHEABLE 4'h5
`define CRIS_ADDR_EXC_SYNDROME    4'h6
`define CRIS_ADDR_GUARDED_MAP     4'h7
`define CRIS_ADDR_LITTLE_END_MAP  4'h8
`define CRIS_ADDR_USER_ATTR_MAP   4'h9
`define CRIS_ADDR_TIMER_CTRL      4'hA
`define CRIS_ADDR_TIMER_FLAGS     4'hB
`define CRIS_ADDR_VERSION_ID      4'hC
`define CRIS_ADDR_FETCH_ADDR      4'hD

// Reset values and the fetch step.
`define CRIS_RST_ZERO    32'h00000000
`define CRIS_RST_GUARDED 32'hFFFFFFFF
`define CRIS_RESET_VEC   32'hFFFFFFFC
`define CRIS_FETCH_STEP  32'h00000004

// Reset kind encodings.
`define CRIS_KIND_NONE   2'h0
`define CRIS_KIND_CORE   2'h1
`define CRIS_KIND_CHIP   2'h2
`define CRIS_KIND_SYSTEM 2'h3

// Field positions.
`define CRIS_LAST_KIND_HI  29
`define CRIS_LAST_KIND_LO  28
`define CRIS_RST_REQ_HI    29
`define CRIS_RST_REQ_LO    28
`define CRIS_WD_CTRL_HI    29
`define CRIS_WD_CTRL_LO    28
`define CRIS_WD_KIND_HI    29
`define CRIS_WD_KIND_LO    28

// Hold counter start value; HOLD lasts one cycle more than this while initial state is applied.
`define CRIS_HOLD_CYCLES 4'h4

`endif

// ---- core/cris_core_reset.v ----
// Core reset sequencer: source merging, reset logging, initial state, fetch.
//
// Functional notes
// - Any reset halts execution at once and discards processor state.
// - Record cause in two-bit reset field: 01 core, 10 chip, 11 system.
// - External reset pin during operation is always logged as system reset.
// - Initialization is identical for every reset kind.
// - Core reset hits execution and caches; chip reset also on-chip peripherals.
// - Watchdog second time-out resets the core when so programmed.
// - Non-zero write to reset-request field of debug control zero resets.
// - Machine-state register clears to zero on reset.
// - Debug controls, cacheable maps, syndrome, endian, user maps clear to zero.
// - Guarded region map sets to all ones on reset.
// - Watchdog-reset control field clears on reset; other timer bits undefined.
// - Watchdog-reset kind uses reset encoding, reads 00 if watchdog not cause.
// - Registers without listed reset value are not initialized.
// - First fetch after initialization is at the reset vector FFFF_FFFC.
// - Sequential fetch past the reset vector wraps to address zero.
// - Reset field is ignored when testing debug log clear for timer thaw.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "cris_defs.vh"

////////////////////////////////////////////////////////////////////////
// Overview.
// Six things can start a reset: the power-up reset input, a rising edge
// on the external system pin, a chip reset request, a request from the debug
// port, a watchdog second time-out when its control field asks for one, and
// a software write with a non-zero reset-request field in debug control zero.
// All but the reset input arrive synchronous to clk, so plain logic merges them
// into one request, and a fixed priority picks the kind that gets logged.
//
// A request is honoured only while the core runs. One that arrives while
// the core is held or booting is dropped: the reset under way ends in the
// same initial state, so only its logged kind and the scope of its strobes are lost.
//
// Timeline of one reset, counted from the edge that takes the request.
// Edge 0: halt, unit reset and the scope strobes rise; fetch stops.
// Edges 1 to 5: HOLD, with the registers loaded on every one of them.
// Edge 5: the unit reset falls, while halt stays up for the boot cycle.
// Edge 6: BOOT; halt falls with the fetch address at the vector.
// Edge 7: the first fetch is offered as valid.
// After power-up the same timeline holds, with the reset input itself
// standing in for edge 0.
//
// Hazards and limits.
// The system pin is edge sensitive: a pin held high through a reset does
// not start a second one and must drop before it can be used again.
// Registers without a defined reset value are zeroed by the reset input
// but keep what they held through any later reset, so boot code must
// write them before it reads them.
// The watchdog is honoured only when its control field names a kind; the
// reset clears that field, so software must arm it again after each reset.
// The version word is a fixed parameter and only tells builds apart.

module cris_core_reset #(
	parameter [31:0] VERSION_ID = 32'h0A5A0001 // Arbitrary identity value.
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        sys_reset_pin,
	input  wire        chip_reset_req,
	input  wire        dbg_port_reset_req,
	input  wire [1:0]  dbg_port_reset_kind,
	input  wire        watchdog_second_timeout,
	input  wire        fetch_advance,
	input  wire        fetch_is_branch,
	input  wire [31:0] fetch_branch_target,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg         core_halt,
	output reg         core_unit_reset,
	output reg         chip_periph_reset,
	output reg         system_reset_out,
	output reg  [31:0] fetch_addr,
	output reg         fetch_valid,
	output reg         timers_thawed
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer states.
	localparam [1:0] ST_RUN  = 2'h0;
	localparam [1:0] ST_HOLD = 2'h1;
	localparam [1:0] ST_BOOT = 2'h2;

	reg [1:0]  state_ff;
	reg [1:0]  nxt_state;
	reg [3:0]  hold_cnt_ff;
	reg [1:0]  kind_ff;
	reg        wd_caused_ff;
	reg        sys_pin_q_ff;

	reg [31:0] machine_state_ff;
	reg [31:0] debug_ctrl_zero_ff;
	reg [31:0] debug_ctrl_one_ff;
	reg [31:0] debug_event_log_ff;
	reg [31:0] data_cacheable_map_ff;
	reg [31:0] instr_cacheable_map_ff;
	reg [31:0] exception_syndrome_ff;
	reg [31:0] guarded_region_map_ff;
	reg [31:0] little_endian_region_map_ff;
	reg [31:0] user_attr_region_map_ff;
	reg [31:0] timer_ctrl_ff;
	reg [31:0] timer_flags_ff;

	wire       wr_dbg0;
	wire [1:0] sw_req;
	wire       wd_fire;
	wire       pin_edge;
	wire       any_req;
	wire       dbg_hit;
	wire [1:0] scope_kind;
	reg  [1:0] req_kind;

	// Sign of a write to a given register index.
	// One decode for every register keeps the write qualifier in one place.
	function wr_hit;
		input [3:0] addr;
		input [3:0] idx;
		input       wr;
		begin
			wr_hit = wr && (addr == idx);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset request decode. Inputs are already synchronous to clk.
	assign wr_dbg0 = wr_hit(reg_addr, `CRIS_ADDR_DEBUG_CTRL_ZERO, reg_wr);
	assign sw_req  = wr_dbg0 ?
		reg_wdata[`CRIS_RST_REQ_HI:`CRIS_RST_REQ_LO] : `CRIS_KIND_NONE;
	// Watchdog acts only when its control field asks for a reset.
	assign wd_fire = watchdog_second_timeout &&
		(timer_ctrl_ff[`CRIS_WD_CTRL_HI:`CRIS_WD_CTRL_LO] !=
		`CRIS_KIND_NONE);
	// Pin rising edge; a pin held during a reset does not retrigger.
	assign pin_edge = sys_reset_pin && !sys_pin_q_ff;
	// A debug request that names no kind is a no-op, so a stray request
	// line on its own can never reset the core.
	assign dbg_hit  = dbg_port_reset_req &&
		(dbg_port_reset_kind != `CRIS_KIND_NONE);
	// Requests outside RUN are dropped; the reset under way covers them.
	assign any_req  = (state_ff == ST_RUN) && (pin_edge || chip_reset_req ||
		dbg_hit || wd_fire || (sw_req != `CRIS_KIND_NONE));
	// Scope of the strobes: the new kind on the request edge, then the
	// logged one. Using the log alone would lag one cycle behind.
	assign scope_kind = any_req ? req_kind : kind_ff;

	// Priority: pin, debugger, watchdog, software, chip request.
	always @* begin
		if (pin_edge)
			req_kind = `CRIS_KIND_SYSTEM;
		else if (dbg_hit)
			req_kind = dbg_port_reset_kind;
		else if (wd_fire)
			req_kind = timer_ctrl_ff[`CRIS_WD_CTRL_HI:`CRIS_WD_CTRL_LO];
		else if (sw_req != `CRIS_KIND_NONE)
			req_kind = sw_req;
		else
			req_kind = `CRIS_KIND_CHIP;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state. HOLD lasts until the counter has run down, then
	// one BOOT cycle lets the fetch path settle on the vector before the
	// halt is lifted.
	always @* begin
		case (state_ff)
		ST_RUN:  nxt_state = any_req ? ST_HOLD : ST_RUN;
		ST_HOLD: nxt_state = (hold_cnt_ff == 4'h0) ? ST_BOOT : ST_HOLD;
		ST_BOOT: nxt_state = ST_RUN;
		default: nxt_state = ST_HOLD;
		endcase
	end

	// Sequencer, reset logging and output strobes.
	// The strobes nest: core only, then on-chip peripherals, then system.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff          <= ST_HOLD;
			hold_cnt_ff       <= `CRIS_HOLD_CYCLES;
			kind_ff           <= `CRIS_KIND_SYSTEM; // Power-up is a system reset.
			wd_caused_ff      <= 1'b0;
			sys_pin_q_ff      <= 1'b0;
			core_halt         <= 1'b1;
			core_unit_reset   <= 1'b1;
			chip_periph_reset <= 1'b1;
			system_reset_out  <= 1'b1;
		end else begin
			state_ff     <= nxt_state;
			sys_pin_q_ff <= sys_reset_pin;
			if (any_req) begin
				hold_cnt_ff  <= `CRIS_HOLD_CYCLES;
				kind_ff      <= req_kind;
				// Only a watchdog that wins the priority is reported.
				wd_caused_ff <= !pin_edge && !dbg_hit && wd_fire;
			end else if (state_ff == ST_HOLD && hold_cnt_ff != 4'h0) begin
				hold_cnt_ff <= hold_cnt_ff - 4'h1;
			end
			// Halt at once on a request; scope follows the kind.
			core_halt         <= (nxt_state != ST_RUN);
			core_unit_reset   <= (nxt_state == ST_HOLD);
			chip_periph_reset <= (nxt_state == ST_HOLD) &&
				(scope_kind >= `CRIS_KIND_CHIP);
			system_reset_out  <= (nxt_state == ST_HOLD) &&
				(scope_kind == `CRIS_KIND_SYSTEM);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Architectural registers. Same initial values for every kind.
	// Only registers with defined reset values are loaded in HOLD.
	// Loading on every HOLD cycle rather than once means a write that slips
	// in on the request edge is overwritten before the core restarts.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			machine_state_ff            <= `CRIS_RST_ZERO;
			debug_ctrl_zero_ff          <= `CRIS_RST_ZERO;
			debug_ctrl_one_ff           <= `CRIS_RST_ZERO;
			debug_event_log_ff          <= `CRIS_RST_ZERO;
			data_cacheable_map_ff       <= `CRIS_RST_ZERO;
			instr_cacheable_map_ff      <= `CRIS_RST_ZERO;
			exception_syndrome_ff       <= `CRIS_RST_ZERO;
			guarded_region_map_ff       <= `CRIS_RST_GUARDED;
			little_endian_region_map_ff <= `CRIS_RST_ZERO;
			user_attr_region_map_ff     <= `CRIS_RST_ZERO;
			timer_ctrl_ff               <= `CRIS_RST_ZERO;
			timer_flags_ff              <= `CRIS_RST_ZERO;
		end else if (state_ff == ST_HOLD) begin
			machine_state_ff            <= `CRIS_RST_ZERO;
			debug_ctrl_zero_ff          <= `CRIS_RST_ZERO;
			debug_ctrl_one_ff           <= `CRIS_RST_ZERO;
			data_cacheable_map_ff       <= `CRIS_RST_ZERO;
			instr_cacheable_map_ff      <= `CRIS_RST_ZERO;
			exception_syndrome_ff       <= `CRIS_RST_ZERO;
			little_endian_region_map_ff <= `CRIS_RST_ZERO;
			user_attr_region_map_ff     <= `CRIS_RST_ZERO;
			guarded_region_map_ff       <= `CRIS_RST_GUARDED;
			// Only the watchdog field of the timer control is defined.
			timer_ctrl_ff[`CRIS_WD_CTRL_HI:`CRIS_WD_CTRL_LO] <=
				`CRIS_KIND_NONE;
			debug_event_log_ff[`CRIS_LAST_KIND_HI:`CRIS_LAST_KIND_LO] <=
				kind_ff;
			timer_flags_ff[`CRIS_WD_KIND_HI:`CRIS_WD_KIND_LO] <=
				wd_caused_ff ? kind_ff : `CRIS_KIND_NONE;
		end else begin
			// Software writes; the reset field of the log is hardware-owned.
			if (wr_hit(reg_addr, `CRIS_ADDR_MACHINE_STATE, reg_wr))
				machine_state_ff <= reg_wdata;
			if (wr_dbg0)
				debug_ctrl_zero_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_DEBUG_CTRL_ONE, reg_wr))
				debug_ctrl_one_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_DEBUG_EVENT_LOG, reg_wr)) begin
				debug_event_log_ff[31:30] <= reg_wdata[31:30];
				debug_event_log_ff[27:0]  <= reg_wdata[27:0];
			end
			if (wr_hit(reg_addr, `CRIS_ADDR_DATA_CACHEABLE, reg_wr))
				data_cacheable_map_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_INSTR_CACHEABLE, reg_wr))
				instr_cacheable_map_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_EXC_SYNDROME, reg_wr))
				exception_syndrome_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_GUARDED_MAP, reg_wr))
				guarded_region_map_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_LITTLE_END_MAP, reg_wr))
				little_endian_region_map_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_USER_ATTR_MAP, reg_wr))
				user_attr_region_map_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_TIMER_CTRL, reg_wr))
				timer_ctrl_ff <= reg_wdata;
			if (wr_hit(reg_addr, `CRIS_ADDR_TIMER_FLAGS, reg_wr))
				timer_flags_ff <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fetch address: vector after init, then sequential or branch.
	// The vector is the last word, so the plain add wraps to zero.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_addr  <= `CRIS_RESET_VEC;
			fetch_valid <= 1'b0;
		end else if (state_ff != ST_RUN || any_req) begin
			// Nothing is offered while held, nor on the request edge itself.
			fetch_addr  <= `CRIS_RESET_VEC;
			fetch_valid <= 1'b0;
		end else begin
			fetch_valid <= 1'b1;
			// A branch target is used as given; keeping it word aligned is
			// the business of whoever decodes the branch.
			if (fetch_advance && fetch_valid) begin
				if (fetch_is_branch)
					fetch_addr <= fetch_branch_target;
				else
					fetch_addr <= fetch_addr + `CRIS_FETCH_STEP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer thaw: log clear apart from the reset field. Read port.
	// Read data stand for one cycle and are zero otherwise, so a stale word
	// is never taken for a fresh answer.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			timers_thawed <= 1'b0;
			reg_rdata     <= `CRIS_RST_ZERO;
		end else begin
			timers_thawed <= (debug_event_log_ff[31:30] == 2'h0) &&
				(debug_event_log_ff[27:0] == 28'h0000000);
			if (reg_rd) begin
				case (reg_addr)
				`CRIS_ADDR_MACHINE_STATE:   reg_rdata <= machine_state_ff;
				`CRIS_ADDR_DEBUG_CTRL_ZERO: reg_rdata <= debug_ctrl_zero_ff;
				`CRIS_ADDR_DEBUG_CTRL_ONE:  reg_rdata <= debug_ctrl_one_ff;
				`CRIS_ADDR_DEBUG_EVENT_LOG: reg_rdata <= debug_event_log_ff;
				`CRIS_ADDR_DATA_CACHEABLE:  reg_rdata <= data_cacheable_map_ff;
				`CRIS_ADDR_INSTR_CACHEABLE: reg_rdata <= instr_cacheable_map_ff;
				`CRIS_ADDR_EXC_SYNDROME:    reg_rdata <= exception_syndrome_ff;
				`CRIS_ADDR_GUARDED_MAP:     reg_rdata <= guarded_region_map_ff;
				`CRIS_ADDR_LITTLE_END_MAP:
					reg_rdata <= little_endian_region_map_ff;
				`CRIS_ADDR_USER_ATTR_MAP:
					reg_rdata <= user_attr_region_map_ff;
				`CRIS_ADDR_TIMER_CTRL:      reg_rdata <= timer_ctrl_ff;
				`CRIS_ADDR_TIMER_FLAGS:     reg_rdata <= timer_flags_ff;
				`CRIS_ADDR_VERSION_ID:      reg_rdata <= VERSION_ID;
				`CRIS_ADDR_FETCH_ADDR:      reg_rdata <= fetch_addr;
				default:                    reg_rdata <= `CRIS_RST_ZERO;
				endcase
			end else begin
				reg_rdata <= `CRIS_RST_ZERO;
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/cris_core_reset_sva.sv ----
// Port-level assertions for the core reset sequencer.
`timescale 1ns/1ns
`default_nettype none
module cris_core_reset_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sys_reset_pin,
	input wire logic        chip_reset_req,
	input wire logic        dbg_port_reset_req,
	input wire logic [1:0]  dbg_port_reset_kind,
	input wire logic        watchdog_second_timeout,
	input wire logic        fetch_advance,
	input wire logic        fetch_is_branch,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        core_halt,
	input wire logic        core_unit_reset,
	input wire logic        chip_periph_reset,
	input wire logic        system_reset_out,
	input wire logic [31:0] fetch_addr,
	input wire logic        fetch_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// Requests count only while running, so the request checks gate on fetch_valid.
	AST_PIN_SCOPE: assert property (
		$rose(sys_reset_pin) && fetch_valid |=> core_halt && system_reset_out)
		else $error("pin reset not taken as system reset");
	AST_SCOPE_NEST: assert property (
		system_reset_out |-> chip_periph_reset && core_unit_reset)
		else $error("system reset without chip and unit reset");
	AST_HOLD_LEN: assert property (
		$rose(core_unit_reset) |-> core_unit_reset[*5] ##1 !core_unit_reset)
		else $error("hold length wrong");
	AST_BOOT_FETCH: assert property (
		$fell(core_unit_reset) |-> core_halt ##1 !core_halt
		##1 fetch_valid && fetch_addr == 32'hFFFFFFFC)
		else $error("first fetch not at vector");
	AST_FETCH_STEP: assert property (
		fetch_valid && fetch_advance && !fetch_is_branch && !core_halt
		&& !$rose(sys_reset_pin) && !chip_reset_req && !dbg_port_reset_req
		&& !watchdog_second_timeout && !reg_wr
		|=> fetch_addr == $past(fetch_addr) + 32'h4)
		else $error("sequential fetch step wrong");
	AST_RD_GUARD: assert property (
		reg_rd && reg_addr == 4'h7 && core_unit_reset &&
		$past(core_unit_reset)
		|=> reg_rdata == 32'hFFFFFFFF) else $error("guarded map not all ones");
	AST_QUIET: assert property (
		fetch_valid && !sys_reset_pin && !chip_reset_req && !dbg_port_reset_req
		&& !watchdog_second_timeout && !reg_wr |=> !core_halt)
		else $error("reset without a request");
	AST_DBG_CORE: assert property (
		dbg_port_reset_req && dbg_port_reset_kind == 2'h1 && fetch_valid
		&& !sys_reset_pin |=> core_unit_reset && !chip_periph_reset)
		else $error("debugger core reset scope wrong");
	AST_CHIP: assert property (
		chip_reset_req && fetch_valid && !sys_reset_pin && !dbg_port_reset_req
		&& !watchdog_second_timeout && !reg_wr
		|=> chip_periph_reset && !system_reset_out)
		else $error("chip reset scope wrong");
endmodule
`default_nettype wire

// ---- tb/cris_reset_net.sv ----
// Model of the external reset network and the debug tool.
`timescale 1ns/1ns
`default_nettype none
module cris_reset_net (
	input  wire logic       clk,
	output var  logic       sys_reset_pin,
	output var  logic       chip_reset_req,
	output var  logic       dbg_port_reset_req,
	output var  logic [1:0] dbg_port_reset_kind,
	output var  logic       watchdog_second_timeout
);
	// Everything quiet at time zero.
	initial begin
		{sys_reset_pin, chip_reset_req, dbg_port_reset_req} = 3'h0;
		dbg_port_reset_kind = 2'h0;
		watchdog_second_timeout = 1'b0;
	end
	// Raise one source for len cycles, long enough to test slow releases.
	task automatic fire(input int src, input logic [1:0] kind, input int len);
		@(posedge clk);
		case (src)
		0: sys_reset_pin <= 1'b1;
		1: chip_reset_req <= 1'b1;
		2: begin
			dbg_port_reset_req <= 1'b1;
			dbg_port_reset_kind <= kind;
		end
		default: watchdog_second_timeout <= 1'b1;
		endcase
		repeat (len) @(posedge clk);
		{sys_reset_pin, chip_reset_req, dbg_port_reset_req} <= 3'h0;
		watchdog_second_timeout <= 1'b0;
		dbg_port_reset_kind <= ~kind; // Released lines never hold a stale kind.
	endtask
endmodule
`default_nettype wire

// ---- tb/cris_core_reset_test.sv ----
// Self-checking bench for the core reset sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module cris_core_reset_test;
	logic        clk = 1'b0, rst = 1'b1, rd_seen = 1'b0;
	logic        fetch_advance = 1'b0, fetch_is_branch = 1'b0;
	logic [31:0] fetch_branch_target = 32'h0, reg_wdata = 32'h0, tgt;
	logic [3:0]  reg_addr = 4'h0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_rdata, fetch_addr;
	logic        sys_reset_pin, chip_reset_req, dbg_port_reset_req;
	logic        watchdog_second_timeout, core_halt, core_unit_reset;
	logic        chip_periph_reset, system_reset_out, fetch_valid;
	logic        timers_thawed;
	logic [1:0]  dbg_port_reset_kind;
	logic [67:0] exp_q [$];
	logic [67:0] ent;
	logic [1:0]  kinds [5] = '{2'h2, 2'h3, 2'h2, 2'h1, 2'h1};
	int          errors = 0, cmp_count = 0, cycles = 0;
	////////////////////////////////////////////////////////////////////////
	always #5 clk = ~clk;
	cris_core_reset uut (.clk, .rst, .sys_reset_pin, .chip_reset_req,
		.dbg_port_reset_req, .dbg_port_reset_kind, .watchdog_second_timeout,
		.fetch_advance, .fetch_is_branch, .fetch_branch_target, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_halt, .core_unit_reset,
		.chip_periph_reset, .system_reset_out, .fetch_addr, .fetch_valid,
		.timers_thawed);
	cris_reset_net net (.clk, .sys_reset_pin, .chip_reset_req,
		.dbg_port_reset_req, .dbg_port_reset_kind, .watchdog_second_timeout);
	// Read data stand only in the cycle after the strobe, so compare there.
	always @(posedge clk) begin
		rd_seen <= reg_rd;
		if (rd_seen) begin
			ent = exp_q.pop_front();
			`CHK($sformatf("reg %h", ent[67:64]), ent[63:32], reg_rdata & ent[31:0])
		end
	end
	// A hang is cut short well beyond the few hundred cycles the run needs.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back({a, e, m});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic step(input logic br, input logic [31:0] t);
		@(posedge clk);
		fetch_advance <= 1'b1;
		fetch_is_branch <= br;
		fetch_branch_target <= t;
		@(posedge clk);
		fetch_advance <= 1'b0;
	endtask
	task automatic wait_run();
		repeat (2) @(posedge clk);
		for (int n = 0; n < 40 && fetch_valid !== 1'b1; n++)
			@(negedge clk);
	endtask
	task automatic check_init(input logic [1:0] k, w);
		rd(4'h3, {2'h0, k, 28'h0}, 32'h30000000);
		rd(4'hB, {2'h0, w, 28'h0}, 32'h30000000);
		rd(4'hA, 32'h0, 32'h30000000);
		rd(4'hD, 32'hFFFFFFFC, 32'hFFFFFFFF);
		for (int a = 0; a < 10; a++)
			if (a != 3)
				rd(a[3:0], a == 7 ? 32'hFFFFFFFF : 32'h0, '1);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Power-up, fetch wrap, every reset source, then ignored requests.
	initial begin
		void'($urandom(32'h505e));
		repeat (8) @(posedge clk);
		`CHK("vector", 32'hFFFFFFFC, fetch_addr)
		rst <= 1'b0;
		rd(4'h7, 32'hFFFFFFFF, '1);
		rd(4'h0, 32'h0, '1);
		wait_run();
		check_init(2'h3, 2'h0);
		`CHK("thawed", 1'b1, timers_thawed)
		$display("power-up test done");
		tgt = $urandom & 32'hFFFFFFFC;
		step(1'b0, 32'h0); // Bench plays boot memory: no branch.
		rd(4'hD, 32'h0, '1);
		step(1'b1, tgt);
		step(1'b0, 32'h0);
		rd(4'hD, tgt + 32'h4, '1);
		$display("fetch test done");
		for (int s = 0; s < 5; s++) begin
			for (int a = 0; a < 10; a++)
				if (a != 3 && a != 10)
					wr(a[3:0], $urandom & 32'hCFFFFFFF);
			case (s)
			0: begin
				wr(4'hA, 32'h20000000);
				net.fire(3, 2'h0, 1);
			end
			1: net.fire(0, 2'h0, 1 + $urandom % 3);
			2: net.fire(1, 2'h0, 1 + $urandom % 3);
			3: net.fire(2, 2'h1, 1 + $urandom % 3);
			default: wr(4'h1, 32'h10000000);
			endcase
			rd(4'h7, 32'hFFFFFFFF, '1); // Read back while still held.
			wait_run();
			check_init(kinds[s], s == 0 ? 2'h2 : 2'h0);
			$display("reset source %0d test done", s);
		end
		net.fire(3, 2'h0, 1);
		net.fire(2, 2'h0, 2);
		repeat (3) @(negedge clk);
		`CHK("still running", 1'b1, fetch_valid)
		$display("ignored request test done");
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
bind cris_core_reset cris_core_reset_sva chk (.clk, .rst, .sys_reset_pin,
	.chip_reset_req, .dbg_port_reset_req, .dbg_port_reset_kind,
	.watchdog_second_timeout, .fetch_advance, .fetch_is_branch, .reg_addr,
	.reg_wr, .reg_rd, .reg_rdata, .core_halt, .core_unit_reset,
	.chip_periph_reset, .system_reset_out, .fetch_addr, .fetch_valid);
`default_nettype wire
